/* pkg/ptc_consts.svh */
// constants for the second-pulse timing command handler
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH
// command subcodes, first byte of each de-framed packet
`define PTC_SUB_CFG 8'h4a
`define PTC_SUB_GATE 8'h4e
`define PTC_SUB_MASK 8'ha5
`define PTC_SUB_SVRST 8'ha6
`define PTC_SUB_SVPAR 8'ha9
`define PTC_SUB_PRIM 8'hab
// accepted packet lengths, subcode byte included
`define PTC_LEN_QUERY 5'h01
`define PTC_LEN_CFG 5'h10
`define PTC_LEN_GATE 5'h02
`define PTC_LEN_MASK 5'h05
`define PTC_LEN_SVRST 5'h02
`define PTC_LEN_SVPAR 5'h0b
`define PTC_LEN_PRIM 5'h02
`define PTC_MAX_LEN 5'h10
// gating selector values
`define PTC_GATE_ALWAYS 3'h2
`define PTC_GATE_SAT1 3'h3
`define PTC_GATE_SAT3 3'h4
// mask bit positions in bytes 1-2
`define PTC_MB_AUTO 5
`define PTC_MB_PRIM 6
`define PTC_MB_SUPP 7
// reset values
`define PTC_RST_DRV 1'b1
`define PTC_RST_TBASE 1'b1
`define PTC_RST_GATE 3'h2
`define PTC_RST_MASK 16'h00c0
`define PTC_RST_SVEN 1'b1
`define PTC_RST_SVSAVE 1'b0
`define PTC_RST_SVLEN 32'h000007d0
`define PTC_RST_THRESH 32'h0000012c
// register byte addresses
`define PTC_REG_THRESH 4'h0
`define PTC_REG_STATUS 4'h4
`define PTC_REG_SVLEN 4'h8
`define PTC_REG_OFSLO 4'hc
// axi responses
`define PTC_RESP_OKAY 2'h0
`define PTC_RESP_SLVERR 2'h2
// timed report deadline after the pulse, and its cycle budget
`define PTC_CLK_HZ 40000000
`define PTC_PRIM_MS 25
`define PTC_PRIM_CYC ((`PTC_PRIM_MS * `PTC_CLK_HZ) / 1000)
`endif

/* pkg/ptc_pkg.sv */
// types of the second-pulse timing command handler
package ptc_pkg;
  // handler phases, one-hot
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_DEC = 3'b010,
    ST_TX = 3'b100
  } ptc_state_e;
  // complete handler state
  typedef struct packed {
    ptc_state_e st;
    logic [4:0] idx;
    logic [15:0][7:0] rx;
    logic [15:0][7:0] tx;
    logic [4:0] tx_n;
    logic cmd_ready;
    logic rpt_valid;
    logic rpt_first;
    logic rpt_last;
    logic drv_on;
    logic tbase;
    logic [63:0] offset;
    logic [2:0] gate_sel;
    logic [15:0] mask;
    logic sv_en;
    logic sv_save;
    logic [31:0] sv_len;
    logic [31:0] thresh;
    logic pend_prim;
    logic pend_supp;
    logic prim_req;
    logic supp_req;
    logic pulse_out;
    logic sv_restart;
    logic nv_save;
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ptc_state_s;
endpackage

/* hdl/ptc_handler.sv */
// second-pulse timing command handler with axi4-lite registers
// Summary of operation
// - every valid pulse config set or query answered, 16-byte report
// - report carries switch, time scale, offset, reserved
// - gating command sets selector; query returns it
// - selector 2 always, 3 one sat, 4 three
// - in fix modes selectors 3/4 follow fixes
// - gating report sent after command executes
// - mask command sets or reads broadcast mask
// - mask bit one enables that broadcast
// - one broadcast per report, best format only
// - bits 5,6,7 auto, primary, supplemental; 3-4 zero
// - mask report mirrors command after execution
// - survey restart when enabled, report mirrors
// - survey params set or read, enable byte 1
// - save flag enables save at survey end
// - survey length 1 to 2^31-1, default 2000
// - timing request type 0 sends report now
// - type 1 defers report to next pulse
// - type 2 sends both reports next pulse
// - bias above threshold disables pulse output
// - accepted pulse config change saved nonvolatile
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "ptc_consts.svh"
module ptc_handler #(
  parameter int ADDR_W = 4
) (
  // clock and synchronous reset
  input wire logic aclk,
  input wire logic aresetn,
  // de-framed command bytes from host link
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_first,
  input wire logic cmd_last,
  output logic cmd_ready,
  // report bytes toward host link
  output logic rpt_valid,
  output logic [7:0] rpt_data,
  output logic rpt_first,
  output logic rpt_last,
  input wire logic rpt_ready,
  // receiver core status
  input wire logic pps_tick,
  input wire logic od_mode,
  input wire logic fix_valid,
  input wire logic [5:0] sats_tracked,
  input wire logic [31:0] bias_unc,
  // actions toward receiver core
  output logic pulse_out,
  output logic prim_req,
  output logic supp_req,
  output logic survey_restart,
  output logic nv_save,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // address must hold the four register words
  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W below 4 cannot decode the map");
  end

  // whole state in one struct, one register process below
  ptc_pkg::ptc_state_s s; // registered state
  ptc_pkg::ptc_state_s n; // next state
  logic gate_ok; // selector allows the pulse now
  logic [4:0] len; // received packet length
  logic [4:0] wr_idx; // byte slot for incoming data
  logic [31:0] rd_val; // read mux value
  logic rd_err; // read to unmapped word
  logic [3:0] ra; // read word address

  // selector decision; fix modes reduce 3/4 to fixes
  // od_mode low means a position fix mode is running
  always_comb begin
    unique case (s.gate_sel)
      `PTC_GATE_SAT1: gate_ok = od_mode ? (sats_tracked >= 6'h01)
                                        : fix_valid;
      `PTC_GATE_SAT3: gate_ok = od_mode ? (sats_tracked >= 6'h03)
                                        : fix_valid;
      default: gate_ok = 1'b1;
    endcase
  end

  // register read mux
  // the result is captured into state, so read data leaves a flop
  always_comb begin
    ra = s_araddr[3:0];
    rd_err = 1'b0;
    rd_val = 32'h00000000;
    // words past the map answer with an error and zero data
    if (s_araddr[ADDR_W-1:2] > 2'h3) begin
      rd_err = 1'b1;
    end else begin
      unique case (ra)
        `PTC_REG_THRESH: rd_val = s.thresh;
        `PTC_REG_STATUS: rd_val = {8'h00, s.mask, 1'b0, s.gate_sel,
                                   s.sv_save, s.sv_en, s.tbase,
                                   s.drv_on};
        `PTC_REG_SVLEN: rd_val = s.sv_len;
        `PTC_REG_OFSLO: rd_val = s.offset[31:0];
        default: rd_err = 1'b1;
      endcase
    end
  end

  // all next-state logic
  always_comb begin
    n = s;
    // idx holds the last byte's slot, so the length counts the subcode
    len = s.idx + 5'h01;
    // cmd_first restarts the index even inside a broken packet
    wr_idx = cmd_first ? 5'h00 : s.idx;
    // one-cycle action pulses drop by default
    n.prim_req = 1'b0;
    n.supp_req = 1'b0;
    n.sv_restart = 1'b0;
    n.nv_save = 1'b0;
    // gated pulse; bias over threshold kills it
    // limitation: the bias figure is taken raw, with no filtering
    n.pulse_out = pps_tick & s.drv_on & gate_ok
                  & (bias_unc <= s.thresh);
    // per-second broadcast, one request per report
    // pending and automatic requests merge, never two per tick
    if (pps_tick) begin
      n.prim_req = s.mask[`PTC_MB_PRIM] | s.pend_prim;
      n.supp_req = s.mask[`PTC_MB_SUPP] | s.pend_supp;
      n.pend_prim = 1'b0;
      n.pend_supp = 1'b0;
    end
    unique case (s.st)
      ptc_pkg::ST_RX: begin
        // collect bytes; overlong packets keep counting until the index holds at 31
        if (cmd_valid) begin
          if (wr_idx < `PTC_MAX_LEN) begin
            n.rx[wr_idx[3:0]] = cmd_data;
          end
          n.idx = (wr_idx == 5'h1f) ? wr_idx : wr_idx + 5'h01;
          if (cmd_last) begin
            n.idx = wr_idx;
            n.st = ptc_pkg::ST_DEC;
            n.cmd_ready = 1'b0;
          end
        end
      end
      ptc_pkg::ST_DEC: begin
        // default: nothing to answer, back to receive
        n.st = ptc_pkg::ST_RX;
        n.cmd_ready = 1'b1;
        // reserved report bytes go out as zero
        n.tx = '0;
        n.tx[0] = s.rx[0];
        n.tx_n = 5'h00;
        unique case (s.rx[0])
          `PTC_SUB_CFG: begin
            if (len == `PTC_LEN_CFG && s.rx[1] <= 8'h01
                && s.rx[2] <= 8'h01) begin
              n.drv_on = s.rx[1][0];
              n.tbase = s.rx[2][0];
              n.offset = {s.rx[4], s.rx[5], s.rx[6], s.rx[7],
                          s.rx[8], s.rx[9], s.rx[10], s.rx[11]};
              n.nv_save = 1'b1;
              n.tx_n = `PTC_LEN_CFG;
            end
            // a set with a bad switch or base byte gets no report
            if (len == `PTC_LEN_QUERY) begin
              n.tx_n = `PTC_LEN_CFG;
            end
            n.tx[1] = {7'h00, n.drv_on};
            n.tx[2] = {7'h00, n.tbase};
            for (int i = 0; i < 8; i++) begin
              n.tx[4 + i] = n.offset[63 - 8 * i -: 8];
            end
          end
          `PTC_SUB_GATE: begin
            if (len == `PTC_LEN_GATE && s.rx[1] >= 8'h02
                && s.rx[1] <= 8'h04) begin
              n.gate_sel = s.rx[1][2:0];
              n.tx_n = `PTC_LEN_GATE;
            end
            if (len == `PTC_LEN_QUERY) begin
              n.tx_n = `PTC_LEN_GATE;
            end
            n.tx[1] = {5'h00, n.gate_sel};
          end
          `PTC_SUB_MASK: begin
            // reserved bytes 3-4 of a set are ignored, never stored
            if (len == `PTC_LEN_MASK) begin
              n.mask = {s.rx[1], s.rx[2]};
            end
            if (len == `PTC_LEN_MASK || len == `PTC_LEN_QUERY) begin
              n.tx_n = `PTC_LEN_MASK;
            end
            n.tx[1] = n.mask[15:8];
            n.tx[2] = n.mask[7:0]; // bytes 3-4 stay zero
          end
          `PTC_SUB_SVRST: begin
            if (len == `PTC_LEN_SVRST && s.rx[1] == 8'h00) begin
              // a disabled survey still gets its mirror report
              n.sv_restart = s.sv_en;
              n.tx_n = `PTC_LEN_SVRST;
            end
          end
          `PTC_SUB_SVPAR: begin
            if (len == `PTC_LEN_SVPAR && s.rx[1] <= 8'h01
                && s.rx[2] <= 8'h01 && s.rx[3][7] == 1'b0
                && {s.rx[3], s.rx[4], s.rx[5], s.rx[6]} != '0) begin
              n.sv_en = s.rx[1][0];
              n.sv_save = s.rx[2][0];
              n.sv_len = {s.rx[3], s.rx[4], s.rx[5], s.rx[6]};
              n.tx_n = `PTC_LEN_SVPAR;
            end
            // out-of-range flags or a zero length get no report
            if (len == `PTC_LEN_QUERY) begin
              n.tx_n = `PTC_LEN_SVPAR;
            end
            n.tx[1] = {7'h00, n.sv_en};
            n.tx[2] = {7'h00, n.sv_save};
            n.tx[3] = n.sv_len[31:24];
            n.tx[4] = n.sv_len[23:16];
            n.tx[5] = n.sv_len[15:8];
            n.tx[6] = n.sv_len[7:0];
          end
          `PTC_SUB_PRIM: begin
            // timing reports are built by the formatter downstream
            if (len == `PTC_LEN_PRIM) begin
              unique case (s.rx[1])
                8'h00: n.prim_req = 1'b1;
                8'h01: n.pend_prim = 1'b1;
                8'h02: begin
                  n.pend_prim = 1'b1;
                  n.pend_supp = 1'b1;
                end
                default: n.pend_prim = n.pend_prim; // dropped
              endcase
            end
          end
          default: n.tx_n = 5'h00; // unknown subcode
        endcase
        // a report to send holds off further commands
        if (n.tx_n != 5'h00) begin
          n.st = ptc_pkg::ST_TX;
          n.cmd_ready = 1'b0;
          n.rpt_valid = 1'b1;
          n.rpt_first = 1'b1;
          n.rpt_last = 1'b0;
        end
      end
      ptc_pkg::ST_TX: begin
        // shift out one byte per accepted beat
        if (rpt_ready) begin
          n.tx = {8'h00, s.tx[15:1]};
          n.tx_n = s.tx_n - 5'h01;
          n.rpt_first = 1'b0;
          // last flag rises as the final byte comes to the front
          n.rpt_last = (s.tx_n == 5'h02);
          if (s.tx_n == 5'h01) begin
            n.rpt_valid = 1'b0;
            n.rpt_last = 1'b0;
            n.st = ptc_pkg::ST_RX;
            n.cmd_ready = 1'b1;
          end
        end
      end
      default: begin
        n.st = ptc_pkg::ST_RX;
        n.cmd_ready = 1'b1;
      end
    endcase
    // axi write: address and data taken in either order
    // a finished write waits in state until its response is taken
    if (s_awvalid && !s.aw_got && !s.bvalid) begin
      n.aw_got = 1'b1;
      n.awaddr = s_awaddr[3:0];
      if (s_awaddr[ADDR_W-1:2] > 2'h3) begin
        n.awaddr = 4'h1;
      end
    end
    if (s_wvalid && !s.w_got && !s.bvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_wdata;
      n.wstrb = s_wstrb;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PTC_RESP_SLVERR;
      // only the threshold is writable; other words are status
      if (s.awaddr == `PTC_REG_THRESH) begin
        n.bresp = `PTC_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (s.wstrb[b]) begin
            n.thresh[8 * b +: 8] = s.wdata[8 * b +: 8];
          end
        end
      end
    end
    if (s.bvalid && s_bready) begin
      n.bvalid = 1'b0;
    end
    // axi read: one cycle to the answer
    // arready drops while an answer stands, one read at a time
    if (s_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = rd_val;
      n.rresp = rd_err ? `PTC_RESP_SLVERR : `PTC_RESP_OKAY;
    end
    if (s.rvalid && s_rready) begin
      n.rvalid = 1'b0;
    end
    // synchronous reset overrides everything
    // trade-off: reset in the same cone keeps a single register
    if (!aresetn) begin
      n = '0;
      n.st = ptc_pkg::ST_RX;
      n.cmd_ready = 1'b1;
      n.drv_on = `PTC_RST_DRV;
      n.tbase = `PTC_RST_TBASE;
      n.gate_sel = `PTC_RST_GATE;
      n.mask = `PTC_RST_MASK;
      n.sv_en = `PTC_RST_SVEN;
      n.sv_save = `PTC_RST_SVSAVE;
      n.sv_len = `PTC_RST_SVLEN;
      n.thresh = `PTC_RST_THRESH;
    end
  end

  // the only state register
  always_ff @(posedge aclk) begin
    s <= n;
  end

  // outputs straight from state flops
  // the ready outputs are decoded from state flops only
  assign cmd_ready = s.cmd_ready;
  assign rpt_valid = s.rpt_valid;
  assign rpt_data = s.tx[0];
  assign rpt_first = s.rpt_first;
  assign rpt_last = s.rpt_last;
  assign pulse_out = s.pulse_out;
  assign prim_req = s.prim_req;
  assign supp_req = s.supp_req;
  assign survey_restart = s.sv_restart;
  assign nv_save = s.nv_save;
  assign s_awready = !s.aw_got && !s.bvalid;
  assign s_wready = !s.w_got && !s.bvalid;
  assign s_bvalid = s.bvalid;
  assign s_bresp = s.bresp;
  assign s_arready = !s.rvalid;
  assign s_rvalid = s.rvalid;
  assign s_rdata = s.rdata;
  assign s_rresp = s.rresp;
endmodule

/* sim/ptc_handler_props.sv */
// port-level checks for the timing command handler
`timescale 1ns/1ps
module ptc_handler_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command and report link
  input wire logic cmd_valid,
  input wire logic cmd_last,
  input wire logic cmd_ready,
  input wire logic rpt_valid,
  input wire logic [7:0] rpt_data,
  input wire logic rpt_last,
  input wire logic rpt_ready,
  // core tick and actions
  input wire logic pps_tick,
  input wire logic pulse_out,
  input wire logic supp_req,
  // register read channel
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // last command byte taken
  sequence s_cmd_end;
    cmd_valid && cmd_ready && cmd_last;
  endsequence
  // last report byte taken
  sequence s_rpt_end;
    rpt_valid && rpt_ready && rpt_last;
  endsequence
  // a stalled report byte must not move under the host
  chk_rpt_hold: assert property (
    rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_data))
    else $error("report byte changed before taken");
  chk_link_busy: assert property (
    s_cmd_end |=> !cmd_ready && !rpt_valid)
    else $error("link not busy while decoding");
  // decode takes one cycle, then a report or a silent drop
  chk_rpt_start: assert property (
    s_cmd_end |-> ##2 (rpt_valid || cmd_ready))
    else $error("no report nor idle after decode");
  chk_rpt_close: assert property (
    s_rpt_end |=> !rpt_valid && cmd_ready)
    else $error("link not released after report");
  chk_rpt_quiet: assert property (
    rpt_valid |-> !cmd_ready)
    else $error("command accepted during report");
  // gated pulse and supplemental request only follow a tick
  chk_pulse_cause: assert property (
    pulse_out |-> $past(pps_tick))
    else $error("pulse without tick");
  chk_supp_cause: assert property (
    supp_req |-> $past(pps_tick))
    else $error("supplemental request without tick");
  chk_read_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data changed before taken");
endmodule
bind ptc_handler ptc_handler_props u_props (
  .aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
  .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rpt_valid(rpt_valid),
  .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_ready(rpt_ready),
  .pps_tick(pps_tick), .pulse_out(pulse_out), .supp_req(supp_req),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata)
);

/* sim/ptc_host.sv */
// host model: sends de-framed packets and takes reports
`timescale 1ns/1ps
module ptc_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // stall the report sink every other cycle
  input wire logic slow,
  // command bytes toward the handler
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_first,
  output logic cmd_last,
  input wire logic cmd_ready,
  // report bytes from the handler
  input wire logic rpt_valid,
  input wire logic [7:0] rpt_data,
  input wire logic rpt_first,
  input wire logic rpt_last,
  output logic rpt_ready
);
  logic [127:0] got = '0; // last report, byte 0 on top
  int cnt = 0; // bytes in last report
  int nrep = 0; // reports taken
  // quiet link at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_first = 1'b0;
    cmd_last = 1'b0;
  end
  // one packet, each byte held until taken
  task automatic send(input logic [127:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      cmd_valid <= 1'b1;
      cmd_data <= p[127-8*i -: 8];
      cmd_first <= (i == 0);
      cmd_last <= (i == n - 1);
      do @(posedge aclk); while (cmd_ready !== 1'b1);
    end
    cmd_valid <= 1'b0;
    cmd_data <= ~cmd_data; // no stale byte left on the bus
  endtask
  // sink: always ready, or toggling to stress the hold
  always @(posedge aclk) begin
    rpt_ready <= aresetn & (slow ? ~rpt_ready : 1'b1);
    if (rpt_valid && rpt_ready) begin
      // a new report starts from a clean buffer
      if (rpt_first) begin
        cnt = 0;
        got = '0;
      end
      got[127-8*cnt -: 8] = rpt_data;
      cnt = cnt + 1;
      if (rpt_last) nrep = nrep + 1;
    end
  end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the timing command handler
`timescale 1ns/1ps
module tb_top;
  // packet, length, expected report (zero: mirror), its length
  typedef struct {
    logic [127:0] c;
    int cl;
    logic [127:0] e;
    int el;
  } ptc_row_s;
  // core status for one tick and the pulse expected
  typedef struct {
    logic od;
    logic fix;
    logic [5:0] sats;
    logic [31:0] bias;
    logic pul;
  } ptc_tick_s;
  logic aclk, aresetn, slow, pps_tick, od_mode, fix_valid;
  logic [5:0] sats_tracked;
  logic [31:0] bias_unc, s_wdata, s_rdata, rd;
  logic cmd_valid, cmd_first, cmd_last, cmd_ready;
  logic [7:0] cmd_data, rpt_data;
  logic rpt_valid, rpt_first, rpt_last, rpt_ready;
  logic pulse_out, prim_req, supp_req, survey_restart, nv_save;
  logic [3:0] s_awaddr, s_araddr, s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, rs;
  int fail_count = 0, compares = 0, k, p, q;
  int pul_n = 0, pri_n = 0, sup_n = 0, svr_n = 0, nvs_n = 0;
  logic [127:0] exp_b; // expected report bytes
  ptc_row_s rows [11] = '{
    '{{8'ha5, 120'h0}, 1, {40'ha500c00000, 88'h0}, 5},
    '{{8'h4a, 120'h0}, 1, {32'h4a010100, 96'h0}, 16},
    '{{8'h4e, 120'h0}, 1, {16'h4e02, 112'h0}, 2},
    '{{8'ha9, 120'h0}, 1, {88'ha90100000007d000000000, 40'h0}, 11},
    '{{40'ha500400000, 88'h0}, 5, 0, 0},
    '{{16'h4e04, 112'h0}, 2, 0, 0},
    '{{88'ha9010100000005_00000000, 40'h0}, 11, 0, 0},
    '{{16'ha600, 112'h0}, 2, 0, 0},
    '{{32'h4a010000, 64'h3ff0000000000000, 32'h0}, 16, 0, 0},
    '{{88'ha9000000000001_00000000, 40'h0}, 11, 0, 0},
    '{{16'ha600, 112'h0}, 2, 0, 0}
  };
  ptc_tick_s ticks [6] = '{
    '{1'b1, 1'b0, 6'h02, 32'h0, 1'b0},
    '{1'b1, 1'b0, 6'h03, 32'h0, 1'b1},
    '{1'b0, 1'b1, 6'h00, 32'h0, 1'b1},
    '{1'b0, 1'b0, 6'h03, 32'h0, 1'b0},
    '{1'b1, 1'b0, 6'h03, 32'h12d, 1'b0},
    '{1'b1, 1'b0, 6'h03, 32'h12c, 1'b1}
  };
  ptc_handler u_dut (
    .aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_first(cmd_first), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data),
    .rpt_first(rpt_first), .rpt_last(rpt_last), .rpt_ready(rpt_ready),
    .pps_tick(pps_tick), .od_mode(od_mode), .fix_valid(fix_valid),
    .sats_tracked(sats_tracked), .bias_unc(bias_unc),
    .pulse_out(pulse_out), .prim_req(prim_req), .supp_req(supp_req),
    .survey_restart(survey_restart), .nv_save(nv_save),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready)
  );
  ptc_host u_host (
    .aclk(aclk), .aresetn(aresetn), .slow(slow),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_first(cmd_first),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rpt_valid(rpt_valid),
    .rpt_data(rpt_data), .rpt_first(rpt_first), .rpt_last(rpt_last),
    .rpt_ready(rpt_ready)
  );
  // 40 mhz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // count one-cycle actions seen at the ports
  always @(posedge aclk) begin
    pul_n <= pul_n + (pulse_out === 1'b1);
    pri_n <= pri_n + (prim_req === 1'b1);
    sup_n <= sup_n + (supp_req === 1'b1);
    svr_n <= svr_n + (survey_restart === 1'b1);
    nvs_n <= nvs_n + (nv_save === 1'b1);
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // one packet, then a bounded wait for its report
  task automatic xfer(input logic [127:0] c, input int n);
    k = u_host.nrep;
    u_host.send(c, n);
    for (int t = 0; t < 60 && u_host.nrep == k; t++) @(posedge aclk);
  endtask
  // one-cycle tick, then room for the actions to land
  task automatic tick();
    @(posedge aclk);
    pps_tick <= 1'b1;
    @(posedge aclk);
    pps_tick <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // register write: address and data released as each is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    p = 0;
    q = 0;
    while (!(p && q)) begin
      @(posedge aclk);
      if (s_awready === 1'b1) p = 1;
      if (s_wready === 1'b1) q = 1;
      if (p) s_awvalid <= 1'b0;
      if (q) s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1) @(posedge aclk);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask
  // register read; late rready makes the slave hold its answer
  task automatic rdr(input logic [3:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    @(posedge aclk);
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    aresetn = 1'b0;
    slow = 1'b0;
    pps_tick = 1'b0;
    od_mode = 1'b1;
    fix_valid = 1'b0;
    sats_tracked = 6'h00;
    bias_unc = 32'h0;
    s_awaddr = 4'h0;
    s_araddr = 4'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'hf;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (6) @(posedge aclk);
    chk(cmd_ready === 1'b1 && rpt_valid === 1'b0, "reset idle");
    aresetn <= 1'b1;
    foreach (rows[r]) begin
      slow <= r[0];
      xfer(rows[r].c, rows[r].cl);
      chk(u_host.nrep == k + 1, "no report");
      p = rows[r].el ? rows[r].el : rows[r].cl;
      chk(u_host.cnt == p, "report length");
      exp_b = rows[r].el ? rows[r].e : rows[r].c;
      chk(u_host.got === exp_b, "bytes");
    end
    chk(svr_n == 1, "restart count");
    chk(nvs_n == 1, "save count");
    foreach (ticks[i]) begin
      od_mode <= ticks[i].od;
      fix_valid <= ticks[i].fix;
      sats_tracked <= ticks[i].sats;
      bias_unc <= ticks[i].bias;
      p = pul_n;
      q = pri_n;
      k = sup_n;
      tick();
      chk(pul_n - p == int'(ticks[i].pul), "gated pulse");
      chk(pri_n - q == 1 && sup_n == k, "broadcast");
    end
    q = pri_n;
    p = sup_n;
    xfer({16'hab00, 112'h0}, 2);
    chk(pri_n == q + 1 && sup_n == p, "immediate request");
    xfer({16'hab02, 112'h0}, 2);
    chk(pri_n == q + 1, "deferred request");
    tick();
    chk(pri_n == q + 2 && sup_n == p + 1, "both on tick");
    xfer({40'ha500800000, 88'h0}, 5);
    q = pri_n;
    p = sup_n;
    xfer({16'hab01, 112'h0}, 2);
    chk(pri_n == q, "type 1 held back");
    tick();
    chk(pri_n == q + 1 && sup_n == p + 1, "type 1 on tick");
    tick();
    chk(pri_n == q + 1 && sup_n == p + 2, "mask bit 6 off");
    xfer({8'h26, 120'h0}, 1);
    chk(u_host.nrep == k, "unknown subcode");
    xfer({16'h4e05, 112'h0}, 2);
    chk(u_host.nrep == k, "bad selector");
    xfer({32'h4a020000, 96'h0}, 16);
    chk(u_host.nrep == k && nvs_n == 1, "bad switch byte");
    xfer({88'ha9010000000000_00000000, 40'h0}, 11);
    chk(u_host.nrep == k, "zero survey length");
    rdr(4'h0);
    chk(rd === 32'h12c && rs === 2'h0, "threshold");
    wr(4'h8, 32'h5);
    chk(rs === 2'h2, "read-only write");
    rdr(4'h8);
    chk(rd === 32'h1, "survey length");
    rdr(4'h4);
    chk(rd === 32'h8041, "status");
    wr(4'h0, 32'h12d);
    chk(rs === 2'h0, "threshold write");
    rdr(4'h0);
    chk(rd === 32'h12d, "threshold readback");
    bias_unc <= 32'h12d;
    p = pul_n;
    tick();
    chk(pul_n == p + 1, "raised threshold");
    // mid-run reset brings every documented default back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(4'h4);
    chk(rd === 32'hc027, "status after reset");
    rdr(4'h8);
    chk(rd === 32'h7d0, "length after reset");
    rdr(4'h0);
    chk(rd === 32'h12c, "threshold after reset");
    conclude();
  end
endmodule
